// file: rtl/mode_cfg_reg.sv
// operating mode register with its serial port and waveform selector
//
// Behaviour
// - bit 0 bypasses channel-1 high-pass filter
// - bit 1 bypasses post-multiplier low-pass filter
// - bit 2 disables pulse output, resets set
// - bit 3 disables sag detection, resets set
// - bit 5 starts temperature conversion, self-clears
// - soft reset bit resets all but pin synchronisers, receive shifter and data out flops
// - bit 7 selects line-cycle accumulation
// - bit 8 shorts first converter inputs
// - bit 9 shorts second converter inputs
// - bit 10 swaps voltage and current inputs
// - bits 14:13 select waveform source
// - waveform samples are 24 bits wide
// - bit 15 accumulates positive power only
// - command low six bits select register
// - command bit 7 picks write or read
`timescale 1ns/100ps
`default_nettype none

module mode_cfg_reg
  import mode_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic cs_n_i,
  input wire logic temp_done_i,
  input wire logic [SAMPLE_BITS-1:0] power_lpf_i,
  input wire logic [SAMPLE_BITS-1:0] ch1_sample_i,
  input wire logic [SAMPLE_BITS-1:0] ch2_sample_i,
  output logic dout_o,
  output logic dout_oe_o,
  output mode_ctrl_t mode_o,
  output logic temp_start_o,
  output logic soft_reset_o,
  output logic wave_valid_o,
  output logic [SAMPLE_BITS-1:0] wave_data_o
);

  // ==========================================================
  // pin synchronisers
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_d_reg;
  logic din_s1_reg;
  logic din_s2_reg;
  logic cs_n_s1_reg;
  logic cs_n_s2_reg;

  // the first stage is read only by the second stage; the pins gain
  // two clocks of latency, so sclk must hold each level that long
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      din_s1_reg <= 1'b0;
      din_s2_reg <= 1'b0;
      cs_n_s1_reg <= 1'b1;
      cs_n_s2_reg <= 1'b1;
    end
    else
    begin
      sclk_s1_reg <= sclk_i;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      din_s1_reg <= din_i;
      din_s2_reg <= din_s1_reg;
      cs_n_s1_reg <= cs_n_i;
      cs_n_s2_reg <= cs_n_s1_reg;
    end
  end

  // ==========================================================
  // serial port
  logic sclk_fall;
  logic hold_reg;
  logic [7:0] hold_cnt_reg;
  port_state_t state_reg;
  logic [4:0] bit_cnt_reg;
  logic [DATA_BITS-1:0] rx_reg;
  logic [DATA_BITS-1:0] tx_reg;
  logic [DATA_BITS-1:0] rx_word;
  logic cmd_done;
  logic data_done;
  logic commit;
  mode_ctrl_t mode_reg;
  mode_ctrl_t rx_mode;

  // bits are taken on the falling clock edge; the port is deaf
  // during the soft reset hold, so early host traffic is lost
  assign sclk_fall = sclk_d_reg & ~sclk_s2_reg & ~cs_n_s2_reg & ~hold_reg;
  assign rx_word = {rx_reg[DATA_BITS-2:0], din_s2_reg};
  assign rx_mode = mode_ctrl_t'(rx_word);
  assign cmd_done = sclk_fall && (state_reg == ST_CMD)
    && (bit_cnt_reg == 5'(CMD_BITS - 1));
  assign data_done = sclk_fall && (state_reg != ST_CMD)
    && (bit_cnt_reg == 5'(DATA_BITS - 1));
  // only a complete 16-bit write to the mode address commits
  assign commit = data_done && (state_reg == ST_WRITE);

  // command and data phase sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hold_reg || cs_n_s2_reg)
    begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= 5'h00;
    end
    else if (sclk_fall)
    begin
      unique case (state_reg)
        ST_CMD:
        begin
          if (cmd_done)
          begin
            bit_cnt_reg <= 5'h00;
            // bit 6 of the command is ignored; reads of any address
            // run a data phase, writes elsewhere are skipped
            if (!rx_word[CMD_DIR_POS])
              state_reg <= ST_READ;
            else if (rx_word[CMD_ADDR_MSB:0] == MODE_ADDR)
              state_reg <= ST_WRITE;
            else
              state_reg <= ST_SKIP;
          end
          else
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        ST_WRITE, ST_READ, ST_SKIP:
        begin
          if (data_done)
          begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= 5'h00;
          end
          else
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      endcase
    end
  end

  // receive shifter, msb first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_reg <= 16'h0000;
    else if (sclk_fall)
      rx_reg <= rx_word;
  end

  // read shifter: loaded at the end of a read command, then one bit
  // moves out per falling edge; unmapped addresses read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hold_reg)
      tx_reg <= 16'h0000;
    else if (cmd_done && !rx_word[CMD_DIR_POS])
      tx_reg <= (rx_word[CMD_ADDR_MSB:0] == MODE_ADDR) ?
        16'(mode_reg) : 16'h0000;
    else if (sclk_fall && state_reg == ST_READ)
      tx_reg <= {tx_reg[DATA_BITS-2:0], 1'b0};
  end

  // data out driven only during a read phase of a live frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
    end
    else
    begin
      dout_o <= tx_reg[DATA_BITS-1];
      dout_oe_o <= (state_reg == ST_READ) && !cs_n_s2_reg;
    end
  end

  // ==========================================================
  // soft reset sequence
  // a write with the reset bit set reloads the register's reset value and holds
  // all but the pin synchronisers, the receive shifter and the data out flops in reset for the host wait time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_reg <= 1'b0;
      hold_cnt_reg <= 8'h00;
    end
    else if (commit && rx_mode.soft_chip_reset)
    begin
      hold_reg <= 1'b1;
      hold_cnt_reg <= 8'(SOFT_RESET_HOLD_CYC - 1);
    end
    else if (hold_reg)
    begin
      if (hold_cnt_reg == 8'h00)
        hold_reg <= 1'b0;
      else
        hold_cnt_reg <= hold_cnt_reg - 8'h01;
    end
  end

  // the hold flag itself tells the datapath to stay in reset
  assign soft_reset_o = hold_reg;

  // ==========================================================
  // mode register
  // written value applies in the cycle after the last data bit;
  // a write that sets the start bit beats a finishing conversion
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hold_reg)
      mode_reg <= mode_ctrl_t'(MODE_RESET);
    else if (commit)
    begin
      mode_reg <= rx_mode;
      mode_reg.soft_chip_reset <= 1'b0;
      if (rx_mode.soft_chip_reset)
        mode_reg <= mode_ctrl_t'(MODE_RESET);
    end
    else if (temp_done_i)
      mode_reg.temp_conversion_start <= 1'b0;
  end

  // decoded fields leave straight from the register
  assign mode_o = mode_reg;

  // start pulse for the temperature converter
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hold_reg)
      temp_start_o <= 1'b0;
    else
      temp_start_o <= commit && rx_mode.temp_conversion_start
        && !rx_mode.soft_chip_reset;
  end

  // ==========================================================
  // waveform sampling
  logic [9:0] div_reg;
  logic [9:0] rate_mask;
  logic rate_tick;

  // free-running divider; the rate code picks how many low bits wrap
  always_comb
  begin
    unique case (mode_reg.waveform_rate_select)
      2'h0: rate_mask = RATE_MASK_128;
      2'h1: rate_mask = RATE_MASK_256;
      2'h2: rate_mask = RATE_MASK_512;
      2'h3: rate_mask = RATE_MASK_1024;
    endcase
  end

  // the divider wraps at 1024, a multiple of every rate period
  assign rate_tick = (div_reg & rate_mask) == rate_mask;

  // restarted by a soft reset so the first sample is a full period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hold_reg)
      div_reg <= 10'h000;
    else
      div_reg <= div_reg + 10'h001;
  end

  // the reserved source yields zero samples rather than stale data
  always_ff @(posedge clk_i)
  begin
    if (rst_i || hold_reg)
    begin
      wave_valid_o <= 1'b0;
      wave_data_o <= 24'h00_0000;
    end
    else
    begin
      wave_valid_o <= rate_tick;
      if (rate_tick)
      begin
        unique case (mode_reg.waveform_source_select)
          WAVE_SRC_POWER: wave_data_o <= power_lpf_i;
          WAVE_SRC_RESERVED: wave_data_o <= 24'h00_0000;
          WAVE_SRC_CH1: wave_data_o <= ch1_sample_i;
          WAVE_SRC_CH2: wave_data_o <= ch2_sample_i;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/mode_cfg_pkg.sv
// constants and types for the operating mode configuration register
package mode_cfg_pkg;

  // ==========================================================
  // serial command byte layout
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int CMD_DIR_POS = 7;
  localparam int CMD_ADDR_MSB = 5;
  localparam logic [5:0] MODE_ADDR = 6'h09;

  // ==========================================================
  // mode register field positions and reset value
  localparam int TEMP_START_POS = 5;
  localparam int SOFT_RESET_POS = 6;
  localparam logic [15:0] MODE_RESET = 16'h000C;

  // ==========================================================
  // timing: soft reset hold, master clock 10 MHz
  localparam int CLK_KHZ = 10000;
  localparam int SOFT_RESET_HOLD_NS = 18000;
  localparam int SOFT_RESET_HOLD_CYC =
    (SOFT_RESET_HOLD_NS * CLK_KHZ + 999999) / 1000000;

  // waveform rate divider masks: clock/128, /256, /512, /1024
  localparam logic [9:0] RATE_MASK_128 = 10'h07F;
  localparam logic [9:0] RATE_MASK_256 = 10'h0FF;
  localparam logic [9:0] RATE_MASK_512 = 10'h1FF;
  localparam logic [9:0] RATE_MASK_1024 = 10'h3FF;

  // waveform source codes
  localparam logic [1:0] WAVE_SRC_POWER = 2'h0;
  localparam logic [1:0] WAVE_SRC_RESERVED = 2'h1;
  localparam logic [1:0] WAVE_SRC_CH1 = 2'h2;
  localparam logic [1:0] WAVE_SRC_CH2 = 2'h3;
  localparam int SAMPLE_BITS = 24;

  // decoded mode register, bit 15 first
  typedef struct packed {
    logic positive_only_accum;
    logic [1:0] waveform_source_select;
    logic [1:0] waveform_rate_select;
    logic input_swap;
    logic second_input_short;
    logic first_input_short;
    logic line_cycle_accum_mode;
    logic soft_chip_reset;
    logic temp_conversion_start;
    logic analog_converter_suspend;
    logic sag_detect_disable;
    logic pulse_output_disable;
    logic power_lowpass_bypass;
    logic highpass_bypass;
  } mode_ctrl_t;

  // serial port state, one-hot
  typedef enum logic [3:0] {
    ST_CMD = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ = 4'b0100,
    ST_SKIP = 4'b1000
  } port_state_t;

endpackage

// file: sim/mode_cfg_reg_properties.sv
// port assertions for the mode register
`timescale 1ns/100ps
`default_nettype none
module mode_cfg_checker
  import mode_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic temp_done_i,
  input wire logic [SAMPLE_BITS-1:0] power_lpf_i,
  input wire logic [SAMPLE_BITS-1:0] ch1_sample_i,
  input wire logic [SAMPLE_BITS-1:0] ch2_sample_i,
  input wire logic dout_oe_o,
  input wire mode_ctrl_t mode_o,
  input wire logic temp_start_o,
  input wire logic soft_reset_o,
  input wire logic wave_valid_o,
  input wire logic [SAMPLE_BITS-1:0] wave_data_o
);
  // ========
  // helpers: a rate change voids the first gap
  logic [10:0] gap_reg;
  logic gap_ok_reg;
  logic [8:0] hold_reg;
  logic [SAMPLE_BITS-1:0] src_w;
  always_ff @(posedge clk_i)
  begin
    gap_reg <= (rst_i || wave_valid_o) ? 11'h001 : gap_reg + 11'h001;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_reset_o || $changed(mode_o.waveform_rate_select))
      gap_ok_reg <= 1'b0;
    else if (wave_valid_o)
      gap_ok_reg <= 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    hold_reg <= (rst_i || !soft_reset_o) ? 9'h000 : hold_reg + 9'h001;
  end
  always_comb
  begin
    case (mode_o.waveform_source_select)
      WAVE_SRC_POWER: src_w = power_lpf_i;
      WAVE_SRC_CH1: src_w = ch1_sample_i;
      WAVE_SRC_CH2: src_w = ch2_sample_i;
      default: src_w = '0;
    endcase
  end
  // ========
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence hold_rise_s;
    $rose(soft_reset_o);
  endsequence
  sequence hold_run_s;
    soft_reset_o [*8];
  endsequence
  reset_value_a:
    assert property ($fell(rst_i) |-> mode_o == MODE_RESET && !dout_oe_o)
    else $error("bad mode value after reset");
  temp_start_a:
    assert property ($rose(mode_o.temp_conversion_start) |-> temp_start_o)
    else $error("no conversion start pulse");
  temp_clear_a:
    assert property (temp_done_i && mode_o.temp_conversion_start |=>
      !mode_o.temp_conversion_start || temp_start_o)
    else $error("conversion bit not cleared");
  soft_hold_a:
    assert property (hold_rise_s |-> hold_run_s)
    else $error("soft reset hold too short");
  soft_length_a:
    assert property ($fell(soft_reset_o) |->
      hold_reg == 9'(SOFT_RESET_HOLD_CYC))
    else $error("soft reset hold length wrong");
  soft_mode_a:
    assert property ($fell(soft_reset_o) |-> mode_o == MODE_RESET)
    else $error("mode not restored by soft reset");
  idle_release_a:
    assert property (cs_n_i [*6] |-> !dout_oe_o)
    else $error("data out driven while deselected");
  mode_stable_a:
    assert property ($changed(mode_o) && !soft_reset_o &&
      !$past(soft_reset_o) |-> !cs_n_i || $past(temp_done_i))
    else $error("mode changed outside a frame");
  // a pulse seen now was decided under the previous cycle's rate
  wave_rate_a:
    assert property (wave_valid_o && gap_ok_reg |->
      gap_reg == (11'h080 << $past(mode_o.waveform_rate_select)))
    else $error("waveform pulse spacing wrong");
  wave_source_a:
    assert property (wave_valid_o && $stable(mode_o) |->
      wave_data_o == $past(src_w))
    else $error("waveform sample from wrong source");
endmodule
bind mode_cfg_reg mode_cfg_checker mode_cfg_checker_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cs_n_i(cs_n_i),
  .temp_done_i(temp_done_i),
  .power_lpf_i(power_lpf_i),
  .ch1_sample_i(ch1_sample_i),
  .ch2_sample_i(ch2_sample_i),
  .dout_oe_o(dout_oe_o),
  .mode_o(mode_o),
  .temp_start_o(temp_start_o),
  .soft_reset_o(soft_reset_o),
  .wave_valid_o(wave_valid_o),
  .wave_data_o(wave_data_o)
);
`default_nettype wire

// file: sim/serial_host.sv
// host model driving the serial register port
`timescale 1ns/100ps
`default_nettype none
module serial_host
(
  input wire logic clk_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic sclk_o,
  output logic din_o,
  output logic cs_n_o
);
  logic [15:0] rd_reg;
  event done_e;
  // serial clock stands high between frames
  initial
  begin
    sclk_o = 1'b1;
    din_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // n bits msb first; fewer than 24 aborts the word
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] dat,
    input int n);
    logic [23:0] sh;
    sh = {cmd, dat};
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      din_o <= sh[23-i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      // the device launches a new bit about four clocks after each
      // fall, so look one clock earlier while the old bit still stands
      repeat (3) @(posedge clk_i);
      if (i >= 8)
        rd_reg = {rd_reg[14:0], dout_oe_i ? dout_i : ~dout_i};
      @(posedge clk_i);
      sclk_o <= 1'b1;
    end
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    din_o <= ~din_o; // released line must not look held
    repeat (8) @(posedge clk_i);
    if (n == 24 && !cmd[7])
      -> done_e;
  endtask
endmodule
`default_nettype wire

// file: sim/metering_mode_config_register_bench.sv
// self-checking bench for the mode register
`timescale 1ns/100ps
`default_nettype none
module metering_mode_config_register_bench;
  import mode_cfg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic temp_done_i = 1'b0;
  logic sclk, din, cs_n, dout, dout_oe, ts, sr, wv;
  logic [SAMPLE_BITS-1:0] pw = '0, c1 = '0, c2 = '0, wd;
  mode_ctrl_t mode;
  logic [16:0] exp_q[$];
  logic [16:0] note;
  logic [15:0] w;
  int miscompares = 0;
  int checks = 0;
  int ts_count = 0;
  int sr_cycles = 0;

  always #50 clk_i = ~clk_i;

  mode_cfg_reg mode_cfg_reg_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .din_i(din), .cs_n_i(cs_n), .temp_done_i(temp_done_i),
    .power_lpf_i(pw), .ch1_sample_i(c1), .ch2_sample_i(c2),
    .dout_o(dout), .dout_oe_o(dout_oe), .mode_o(mode),
    .temp_start_o(ts), .soft_reset_o(sr), .wave_valid_o(wv),
    .wave_data_o(wd));
  serial_host serial_host_inst (.clk_i(clk_i), .dout_i(dout),
    .dout_oe_i(dout_oe), .sclk_o(sclk), .din_o(din), .cs_n_o(cs_n));

  // sources change every clock so a stale sample shows
  always @(posedge clk_i)
  begin
    pw <= 24'($urandom);
    c1 <= 24'($urandom);
    c2 <= 24'($urandom);
  end

  // count conversion start pulses and soft reset hold cycles
  always @(posedge clk_i)
  begin
    if (ts === 1'b1)
      ts_count++;
    if (sr === 1'b1)
      sr_cycles++;
  end

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // bit 16 of a note also asks for the decoded outputs
  always @(serial_host_inst.done_e)
  begin
    note = exp_q.pop_front();
    cmp(serial_host_inst.rd_reg, note[15:0]);
    if (note[16])
      cmp(mode, note[15:0]);
  end

  task automatic rd(input logic [5:0] a, input logic [16:0] e);
    exp_q.push_back(e);
    serial_host_inst.xfer({2'b00, a}, 16'h0000, 24);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    serial_host_inst.xfer({2'b10, a}, d, 24);
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ========
  // main sequence
  initial
  begin
    w = 16'($urandom(76148));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(MODE_ADDR, {1'b1, MODE_RESET});
    // every rate and source code with random other fields, start and soft reset bits clear
    for (int k = 0; k < 16; k++)
    begin
      w = (16'($urandom) & 16'h879f) | (16'(k) << 11);
      wr(MODE_ADDR, w);
      rd(MODE_ADDR, {1'b1, w});
      repeat (2100) @(posedge clk_i);
    end
    wr(MODE_ADDR, 16'h0020);
    rd(MODE_ADDR, {1'b1, 16'h0020});
    temp_done_i <= 1'b1;
    @(posedge clk_i);
    temp_done_i <= 1'b0;
    rd(MODE_ADDR, {1'b1, 16'h0000});
    wr(6'h0a, 16'hffff);
    rd(6'h0a, {1'b0, 16'h0000});
    serial_host_inst.xfer({2'b10, MODE_ADDR}, 16'hffff, 20);
    rd(MODE_ADDR, {1'b1, 16'h0000});
    wr(MODE_ADDR, 16'h8043);
    repeat (200) @(posedge clk_i);
    rd(MODE_ADDR, {1'b1, MODE_RESET});
    repeat (2) @(posedge clk_i);
    cmp(16'(ts_count), 16'h0001);
    cmp(16'(sr_cycles), 16'(SOFT_RESET_HOLD_CYC));
    stop_test();
  end

  // watchdog well beyond the expected run
  initial
  begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
